/* design/owd_watchdog.v */
// operating watchdog timer: prescaler, 6-bit watchdog counter, APB regs
// assumes APB master on clk, inputs synchronous to clk, reset pin
// open-drain resolved outside from rstPinOut / rstPinOe
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
`include "owd_defines.vh"

module owd_watchdog #(
  parameter LONG_TAP   = `OWD_LONG_TAP,
  parameter SHORT_TAP  = `OWD_SHORT_TAP,
  parameter POR_CYCLES = `OWD_POR_CYCLES,
  parameter PIN_CYCLES = `OWD_PIN_CYCLES
) (
  // clock and reset
  input  wire        clk,
  input  wire        rst,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [17:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output wire        pslverr,
  // system state
  input  wire [7:0]  resetVectorLow,
  input  wire        internalReset,
  input  wire        stopInstr,
  input  wire        stopMode,
  input  wire        waitMode,
  input  wire        monitorMode,
  input  wire        testHighVoltage,
  input  wire        breakActive,
  // reset outputs
  output reg         watchdogReset,
  output wire        rstPinOut,
  output reg         rstPinOe
);

  // ==========================================================
  // constants and helpers
  // ==========================================================
  localparam PW = `OWD_PRE_WIDTH;
  localparam WW = `OWD_WDOG_WIDTH;

  // reported time figures, derived from the tap choice
  localparam LONG_CYCLES  = `OWD_LONG_CYCLES;
  localparam SHORT_CYCLES = `OWD_SHORT_CYCLES;

  // true when all prescaler bits below the tap are ones;
  // a loop over all bits keeps the tap a plain run-time argument
  function tapDone;
    input [PW-1:0] value;
    input integer  tap;
    integer        i;
    begin
      tapDone = 1'b1;
      for (i = 0; i < PW; i = i + 1) begin
        if (i < tap && !value[i]) begin
          tapDone = 1'b0;
        end
      end
    end
  endfunction

  // index match for an APB byte address
  function hitIdx;
    input [17:0] addr;
    input [17:0] idx;
    begin
      hitIdx = (addr[17:2] == idx[15:0]) && (addr[1:0] == 2'h0);
    end
  endfunction

  // ==========================================================
  // apb decode
  // ==========================================================
  wire setupPhase = psel && !penable;
  wire accessWr   = psel && penable && pwrite;

  wire hitSvc   = hitIdx(paddr, `OWD_IDX_SERVICE);
  wire hitCfg   = hitIdx(paddr, `OWD_IDX_CONFIG);
  wire hitCause = hitIdx(paddr, `OWD_IDX_CAUSE);
  wire hitBrk   = hitIdx(paddr, `OWD_IDX_BREAK);
  wire mapped   = hitSvc || hitCfg || hitCause || hitBrk;

  // zero wait states keep the service latency fixed; an unmapped or
  // misaligned address still completes, flagged by pslverr
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // ==========================================================
  // software registers
  // ==========================================================
  // register map, byte address four times the index:
  //   service 0x3fffc  any write services, read gives vector low byte
  //   config  0x0007c  b0 disable, b1 short rate, b2 pin enable
  //   cause   0x00400  b0 timeout cause, write one to clear
  //   break   0x00404  b0 watchdog off in a monitor-mode break
  // config is write-once so runaway code cannot switch the watchdog off
  reg [2:0] cfgBits;
  reg       cfgLocked;
  reg       causeFlag;
  reg       brkWdogDis;

  // overflow strobe, declared here because the cause flag needs it early
  wire      timeout;

  wire serviceWrite = accessWr && hitSvc;
  wire cfgDisable   = cfgBits[`OWD_CFG_DISABLE];
  wire rateShort    = cfgBits[`OWD_CFG_RATE];
  wire pinEnable    = cfgBits[`OWD_CFG_RSTPIN];

  // config is write-once after each reset; pin enable clears on POR only
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cfgBits   <= `OWD_CFG_RESET;
      cfgLocked <= 1'b0;
    end else if (internalReset || watchdogReset) begin
      cfgBits   <= cfgBits & 3'h4;
      cfgLocked <= 1'b0;
    end else if (accessWr && hitCfg && !cfgLocked) begin
      cfgBits   <= pwdata[2:0];
      cfgLocked <= 1'b1;
    end
  end

  // cause flag: set by timeout, write one clears, set wins
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      causeFlag <= 1'b0;
    end else if (timeout) begin
      causeFlag <= 1'b1;
    end else if (accessWr && hitCause && pwdata[`OWD_CAUSE_WDOG]) begin
      causeFlag <= 1'b0;
    end
  end

  // break auxiliary disable bit; it only matters while the core sits
  // in a monitor-mode break
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      brkWdogDis <= 1'b0;
    end else if (accessWr && hitBrk) begin
      brkWdogDis <= pwdata[`OWD_BRK_WDOG_DIS];
    end
  end

  // read data captured in setup so it is stable for the access phase
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      prdata <= 32'h0;
    end else if (setupPhase) begin
      if (hitSvc) begin
        prdata <= {24'h0, resetVectorLow};
      end else if (hitCfg) begin
        prdata <= {29'h0, cfgBits};
      end else if (hitCause) begin
        prdata <= {31'h0, causeFlag};
      end else if (hitBrk) begin
        prdata <= {31'h0, brkWdogDis};
      end else begin
        prdata <= 32'h0;
      end
    end
  end

  // ==========================================================
  // power-on settle
  // ==========================================================
  reg [12:0] porCount;
  reg        porDone;

  // prescaler held clear until the settle count runs out; 13 bits give
  // room for the full settle length, and the counter then parks
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      porCount <= 13'h0;
      porDone  <= 1'b0;
    end else if (!porDone) begin
      porCount <= porCount + 13'h1;
      if (porCount == POR_CYCLES[12:0] - 13'h1) begin
        porDone <= 1'b1;
      end
    end
  end

  // ==========================================================
  // enables and clears
  // ==========================================================
  // wait mode is deliberately absent from the run term: the core sleeps
  // but the oscillator runs, so only service writes hold off a timeout;
  // waitMode is kept as a port only to document that choice
  wire wdogOff = cfgDisable
              || (monitorMode && testHighVoltage)
              || (monitorMode && breakActive && brkWdogDis);
  wire run     = porDone && !stopMode && !wdogOff;
  wire unusedWait = waitMode;

  // every reset, the stop instruction, stop mode and the power-on settle
  // clear the whole prescaler; a service clears only its upper stages, so
  // software cannot shift the phase of the low four bits
  wire anyReset = internalReset || watchdogReset;
  wire preClearAll = !porDone || stopInstr || stopMode
                  || anyReset;
  wire preClearHigh = serviceWrite;

  wire [PW-1:0] preCount;

  owd_prescaler #(
    .WIDTH     (PW)
  ) uPrescaler (
    .clk       (clk),
    .rst       (rst),
    .run       (run),
    .clearAll  (preClearAll),
    .clearHigh (preClearHigh),
    .count     (preCount)
  );

  // ==========================================================
  // watchdog counter
  // ==========================================================
  reg [WW-1:0] wdogCount;

  // rate select picks the tap that feeds the counter; a service leaves
  // prescaler bits 3..0 running, so the overflow lands up to 16 cycles
  // short of 64 whole tap periods, which is where the -16 in the nominal
  // LONG_CYCLES and SHORT_CYCLES figures comes from
  wire tick = run && !preClearHigh
           && (rateShort ? tapDone(preCount, SHORT_TAP)
                         : tapDone(preCount, LONG_TAP));
  assign timeout = tick && (&wdogCount);

  // a disabled watchdog holds its count at zero
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wdogCount <= {WW{1'b0}};
    end else if (anyReset || serviceWrite || wdogOff) begin
      wdogCount <= {WW{1'b0}};
    end else if (tick) begin
      wdogCount <= wdogCount + {{(WW-1){1'b0}}, 1'b1};
    end
  end

  // ==========================================================
  // reset outputs
  // ==========================================================
  reg [5:0] pinCount;

  // reset is the only action; no interrupt path exists
  // one registered pulse; the system reset logic stretches it as needed
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      watchdogReset <= 1'b0;
    end else begin
      watchdogReset <= timeout;
    end
  end

  // open-drain pin pulled low for the fixed length when enabled; the
  // count restarts on every timeout, but the watchdog reset clears the
  // counter first, so a second timeout cannot arrive inside one pulse
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pinCount <= 6'h0;
      rstPinOe <= 1'b0;
    end else if (timeout && pinEnable) begin
      pinCount <= PIN_CYCLES[5:0] - 6'h1;
      rstPinOe <= 1'b1;
    end else if (pinCount != 6'h0) begin
      pinCount <= pinCount - 6'h1;
    end else begin
      rstPinOe <= 1'b0;
    end
  end

  // pin data is a constant low; only the enable moves, as open drain wants
  assign rstPinOut = 1'b0;

endmodule

/* common/owd_defines.vh */
// constants for the operating watchdog timer block
// assumes inclusion by bare name from the design files
`ifndef OWD_DEFINES_VH
`define OWD_DEFINES_VH

// register indexes; byte address is four times the index
`define OWD_IDX_SERVICE     18'h0ffff
`define OWD_IDX_CONFIG      18'h0001f
`define OWD_IDX_CAUSE       18'h00100
`define OWD_IDX_BREAK       18'h00101

// config_reg_one field positions
`define OWD_CFG_DISABLE     0
`define OWD_CFG_RATE        1
`define OWD_CFG_RSTPIN      2
`define OWD_CFG_RESET       3'h0

// reset_cause_reg and break_aux_reg field positions
`define OWD_CAUSE_WDOG      0
`define OWD_BRK_WDOG_DIS    0

// counter widths
`define OWD_PRE_WIDTH       12
`define OWD_WDOG_WIDTH      6

// timeout lengths in oscillator cycles and prescaler taps producing them
`define OWD_LONG_CYCLES     262128
`define OWD_SHORT_CYCLES    8176
`define OWD_LONG_TAP        12
`define OWD_SHORT_TAP       7

// reset pin drive length and power-on settle time, in cycles
`define OWD_PIN_CYCLES      32
`define OWD_POR_CYCLES      4096

`endif

/* design/owd_prescaler.v */
// 12-bit prescaler shared with the system integration unit
// assumes one clock; clears are synchronous and take effect at the edge
`timescale 1ns/1ps

module owd_prescaler #(
  parameter WIDTH = 12
) (
  // clock and reset
  input  wire             clk,
  input  wire             rst,
  // control
  input  wire             run,
  input  wire             clearAll,
  input  wire             clearHigh,
  // state
  output reg  [WIDTH-1:0] count
);

  // ==========================================================
  // counter
  // ==========================================================
  // a full clear beats a partial one; stages 12..5 are bits 11..4
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      count <= {WIDTH{1'b0}};
    end else if (clearAll) begin
      count <= {WIDTH{1'b0}};
    end else if (clearHigh) begin
      count <= {{(WIDTH-4){1'b0}}, count[3:0] + 4'h1};
    end else if (run) begin
      count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

endmodule

/* test/owd_watchdog_checker.sv */
// port assertions for the watchdog block
// assumes one clock clk and async active-high reset rst
`timescale 1ns/1ps
`include "owd_defines.vh"

module owd_watchdog_checker #(
  parameter SHORT_TAP  = `OWD_SHORT_TAP,
  parameter PIN_CYCLES = `OWD_PIN_CYCLES
) (
  // clock and reset
  input logic        clk,
  input logic        rst,
  // apb side
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [17:0] paddr,
  input logic [31:0] prdata,
  input logic        pslverr,
  // system side
  input logic [7:0]  resetVectorLow,
  input logic        internalReset,
  input logic        monitorMode,
  input logic        testHighVoltage,
  input logic        watchdogReset,
  input logic        rstPinOut,
  input logic        rstPinOe
);
  localparam logic [17:0] SVC = `OWD_IDX_SERVICE << 2;
  localparam int MIN_RUN = 63 << SHORT_TAP;
  logic [15:0] sinceClr;
  logic [7:0]  oeCount;
  wire         svcWr = psel && penable && pwrite && paddr == SVC;
  wire         clrAny = svcWr || internalReset || watchdogReset ||
                        (monitorMode && testHighVoltage);
  // ===
  // cycles since a service, a reset or the test-voltage hold last forced the counter to zero, and pin low length;
  // the short timeout is the lower bound for any timeout
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      sinceClr <= 16'h0000;
      oeCount  <= 8'h00;
    end else begin
      if (clrAny)
        sinceClr <= 16'h0000;
      else if (sinceClr != 16'hffff)
        sinceClr <= sinceClr + 16'h0001;
      oeCount <= rstPinOe ? oeCount + 8'h01 : 8'h00;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_pulse_single: assert property (watchdogReset |=> !watchdogReset)
    else $error("watchdog reset longer than one cycle");
  a_run_full: assert property (watchdogReset |-> sinceClr >= MIN_RUN)
    else $error("timeout came too soon after a clear");
  a_pin_length: assert property ($fell(rstPinOe) |-> oeCount == PIN_CYCLES)
    else $error("reset pin low for wrong length");
  a_pin_data: assert property (rstPinOut == 1'b0)
    else $error("reset pin data not low");
  a_monitor_hold: assert property ((monitorMode && testHighVoltage) [*2]
    |-> !watchdogReset)
    else $error("timeout while held off by test voltage");
  a_read_vector: assert property (psel && penable && !pwrite && paddr == SVC
    |-> prdata == {24'h000000, $past(resetVectorLow)})
    else $error("service read not the vector byte");
  a_err_phase: assert property (pslverr |-> psel && penable)
    else $error("error flag outside access phase");
  a_svc_mapped: assert property (psel && penable && paddr == SVC |-> !pslverr)
    else $error("service address refused");
  c_timeout: cover property (watchdogReset);
  c_pin: cover property ($fell(rstPinOe));
  c_service: cover property (svcWr);
endmodule

bind owd_watchdog owd_watchdog_checker #(.SHORT_TAP(SHORT_TAP),
  .PIN_CYCLES(PIN_CYCLES)) chk (.clk(clk), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pslverr(pslverr), .resetVectorLow(resetVectorLow),
  .internalReset(internalReset), .monitorMode(monitorMode),
  .testHighVoltage(testHighVoltage), .watchdogReset(watchdogReset),
  .rstPinOut(rstPinOut), .rstPinOe(rstPinOe));

/* test/test_owd_watchdog.sv */
// self-checking bench for the watchdog block over apb
// assumes shortened prescaler taps so each timeout fits a short run
`timescale 1ns/1ps
`include "owd_defines.vh"

module test_owd_watchdog;
  localparam int LT = 5;
  localparam int ST = 4;
  localparam logic [17:0] SVC = `OWD_IDX_SERVICE << 2;
  localparam logic [17:0] CFG = `OWD_IDX_CONFIG << 2;
  localparam logic [17:0] CAU = `OWD_IDX_CAUSE << 2;
  localparam logic [17:0] BRK = `OWD_IDX_BREAK << 2;
  logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [17:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rdata;
  logic pready, pslverr, serr, watchdogReset, rstPinOut, rstPinOe;
  logic internalReset = 0, stopInstr = 0, stopMode = 0, waitMode = 0;
  logic monitorMode = 0, testHighVoltage = 0, breakActive = 0;
  logic [7:0] vecLow = 8'h5a;
  int miscompares = 0, nCompared = 0, n;

  owd_watchdog #(.LONG_TAP(LT), .SHORT_TAP(ST), .POR_CYCLES(16),
    .PIN_CYCLES(32)) DUT (.clk(clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .resetVectorLow(vecLow), .internalReset(internalReset),
    .stopInstr(stopInstr), .stopMode(stopMode), .waitMode(waitMode),
    .monitorMode(monitorMode), .testHighVoltage(testHighVoltage),
    .breakActive(breakActive), .watchdogReset(watchdogReset),
    .rstPinOut(rstPinOut), .rstPinOe(rstPinOe));

  // 40 MHz clock
  always #12.5 clk = ~clk;

  // ===
  // comparison and closing helpers
  task automatic conclude();
    if (miscompares == 0 && nCompared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, got);
    nCompared++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chkRange(input string what, input int lo, hi, got);
    nCompared++;
    if (got < lo || got > hi) begin
      miscompares++;
      $display("unexpected %s: expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask
  // ===
  // one apb transfer; request held until pready sampled high
  task automatic apb(input logic w, input logic [17:0] a,
                     input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    rdata = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i == 16) begin
      miscompares++;
      conclude();
    end
  endtask
  // ===
  // bounded waits on the reset outputs
  task automatic waitReset(output int c);
    c = 0;
    while (watchdogReset !== 1'b1 && c < 5000) begin
      @(negedge clk);
      c++;
    end
    if (c >= 5000) begin
      miscompares++;
      conclude();
    end
  endtask
  task automatic quiet(input int cyc);
    int p;
    p = 0;
    repeat (cyc) begin
      @(negedge clk);
      if (watchdogReset !== 1'b0) p++;
    end
    chk("reset pulses", 0, p);
    // hand back on a rising edge so the caller drives on it
    @(posedge clk);
  endtask
  task automatic pinCount(output int h);
    h = 0;
    // the caller stands on the negedge where the reset was seen, and the
    // pin went low at that same rising edge, so count this one too
    repeat (40) begin
      if (rstPinOe === 1'b1) h++;
      @(negedge clk);
    end
  endtask
  task automatic pulseInternal();
    @(posedge clk);
    internalReset <= 1'b1;
    @(posedge clk);
    internalReset <= 1'b0;
  endtask

  // ===
  // main sequence
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    apb(1, SVC, 0);
    apb(0, SVC, 0);
    chk("service read", 32'h0000005a, rdata);
    vecLow <= 8'hc3;
    apb(0, SVC, 0);
    chk("service read new vector", 32'h000000c3, rdata);
    apb(0, CAU, 0);
    chk("cause at start", 0, rdata);
    apb(0, 18'h00200, 0);
    chk("unmapped error", 1, serr);
    // short rate with pin; services in wait mode keep it alive
    apb(1, CFG, 32'h6);
    waitMode <= 1'b1;
    repeat (4) begin
      apb(1, SVC, 32'ha5);
      quiet(800);
    end
    apb(1, SVC, 32'h3c);
    waitReset(n);
    chkRange("short timeout", 63 << ST, (65 << ST) + 4, n);
    pinCount(n);
    chk("pin low cycles", 32, n);
    apb(0, CAU, 0);
    chk("cause flag", 1, rdata);
    apb(1, CAU, 1);
    apb(0, CAU, 0);
    chk("cause cleared", 0, rdata);
    // long rate, pin function off
    apb(1, CFG, 0);
    apb(1, SVC, 0);
    waitReset(n);
    chkRange("long timeout", 63 << LT, (65 << LT) + 4, n);
    pinCount(n);
    chk("pin unused", 0, n);
    // disable bit, then held-off conditions
    apb(1, CFG, 1);
    quiet(3000);
    pulseInternal();
    apb(1, CFG, 2);
    monitorMode <= 1'b1;
    testHighVoltage <= 1'b1;
    quiet(2000);
    testHighVoltage <= 1'b0;
    breakActive <= 1'b1;
    apb(1, BRK, 1);
    quiet(2000);
    monitorMode <= 1'b0;
    breakActive <= 1'b0;
    stopInstr <= 1'b1;
    stopMode <= 1'b1;
    @(posedge clk);
    stopInstr <= 1'b0;
    quiet(2000);
    stopMode <= 1'b0;
    apb(1, SVC, 0);
    quiet(600);
    // internal reset mid-count restarts a full period
    pulseInternal();
    apb(1, CFG, 2);
    waitReset(n);
    chkRange("after internal reset", 63 << ST, (65 << ST) + 4, n);
    conclude();
  end
endmodule
